//--- core/mlcd_pkg.sv
// mlcd_pkg: constants and types shared by the panel controller files.
// assumes a single 25 MHz system clock; no register bus, all settings are ports.
package mlcd_pkg;

    // screen geometry limits
    localparam int PIX_W = 10;
    localparam int LINE_W = 9;
    localparam int MAX_WIDTH = 640;
    localparam int MAX_LINES = 512;
    // line buffer words for the widest line at two bits per pixel
    localparam int BUF_WORDS = MAX_WIDTH * 2 / 16;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 24;
    // frame count wraps at the lcm of every density denominator
    localparam logic [8:0] FRC_PERIOD = 9'h168;

    // panel bus width codes, bus width is 1 << code
    localparam logic [1:0] BW_1 = 2'h0;
    localparam logic [1:0] BW_2 = 2'h1;
    localparam logic [1:0] BW_4 = 2'h2;
    localparam logic [1:0] BW_8 = 2'h3;

    // values after reset
    localparam logic [6:0] ALT_COUNT_RESET = 7'h00;
    localparam logic ALT_OUT_RESET = 1'b0;
    localparam logic [23:0] ADDR_RESET = 24'h000000;
    localparam logic [8:0] LINE_RESET = 9'h000;
    localparam logic [7:0] PWM_RESET = 8'h00;
    // byte step between 16-bit words
    localparam logic [23:0] WORD_BYTES = 24'h000002;

    typedef enum logic [1:0] {DMA_IDLE, DMA_REQ, DMA_READ} mlcd_dma_type;
    typedef enum logic [1:0] {PH_HOLD, PH_DATA, PH_LINE} mlcd_phase_type;

endpackage

//--- core/mlcd_frc.sv
// mlcd_frc: frame rate modulation of one pixel lane.
// assumes frame counts 0..359 and a phase taken from the pixel position.
`timescale 1ns/10ps
`default_nettype none

module mlcd_frc (
    input wire logic [3:0] density,
    input wire logic [8:0] frame,
    input wire logic [3:0] phase,
    output logic pixel_on
);

    // density code to {on frames, period frames}
    function automatic logic [7:0] mlcd_ratio(input logic [3:0] d);
        unique case (d)
            4'h0: mlcd_ratio = 8'h01;
            4'h1: mlcd_ratio = 8'h18;
            4'h2: mlcd_ratio = 8'h15;
            4'h3: mlcd_ratio = 8'h14;
            4'h4: mlcd_ratio = 8'h13;
            4'h5: mlcd_ratio = 8'h25;
            4'h6: mlcd_ratio = 8'h49;
            4'h7: mlcd_ratio = 8'h12;
            4'h8: mlcd_ratio = 8'h59;
            4'h9: mlcd_ratio = 8'h35;
            4'ha: mlcd_ratio = 8'h23;
            4'hb: mlcd_ratio = 8'h34;
            4'hc: mlcd_ratio = 8'h45;
            4'hd: mlcd_ratio = 8'h78;
            4'he: mlcd_ratio = 8'hef;
            4'hf: mlcd_ratio = 8'h11;
        endcase
    endfunction

    logic [7:0] ratio;
    logic [9:0] slot;

    // the phase offset spreads on-frames across neighbours to cut flicker
    always_comb begin
        ratio = mlcd_ratio(density);
        slot = 10'({1'b0, frame} + {6'h00, phase}) % {6'h00, ratio[3:0]};
        pixel_on = slot < {6'h00, ratio[7:4]};
    end

endmodule
`default_nettype wire

//--- core/mlcd_top.sv
// mlcd_top: monochrome panel controller with screen dma, cursor and gray modulation.
// assumes settings come from a register block on the same clock, and that the
// memory returns read data on mem_rdata by the last cycle of each word.
`timescale 1ns/10ps
`default_nettype none

module mlcd_top #(
    parameter int BUF_WORDS = mlcd_pkg::BUF_WORDS
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic controller_on,
    input wire logic bus_grant_n,
    input wire logic [15:0] mem_rdata,
    input wire logic [23:0] screen_start_addr,
    input wire logic [9:0] screen_width,
    input wire logic [8:0] screen_height,
    input wire logic two_bit_pixels,
    input wire logic [1:0] panel_interface_config,
    input wire logic [3:0] clocks_per_transfer,
    input wire logic [5:0] display_clocking_control,
    input wire logic frame_marker_invert,
    input wire logic line_pulse_invert,
    input wire logic shift_clock_invert,
    input wire logic pixel_data_invert,
    input wire logic [6:0] alternate_rate_code,
    input wire logic alternate_on_line,
    input wire logic [15:0] gray_palette_map,
    input wire logic cursor_enable,
    input wire logic cursor_reverse,
    input wire logic [9:0] cursor_x,
    input wire logic [8:0] cursor_y,
    input wire logic [4:0] cursor_width,
    input wire logic [4:0] cursor_height,
    input wire logic cursor_blink_enable,
    input wire logic [6:0] blink_control_reg,
    input wire logic [7:0] contrast_duty,
    output logic bus_request_n,
    output logic [23:0] mem_addr,
    output logic mem_read,
    output logic [7:0] panel_pixel_data,
    output logic frame_marker,
    output logic line_latch_pulse,
    output logic panel_shift_clock,
    output logic crystal_alternate_out,
    output logic contrast_pwm
);

    typedef struct packed {
        mlcd_pkg::mlcd_dma_type dma;
        logic breq_n;
        logic mrd;
        logic [23:0] addr;
        logic [23:0] line_addr;
        logic [6:0] word;
        logic [3:0] cyc;
        logic [8:0] fetch_y;
        logic filled;
        logic [BUF_WORDS-1:0][15:0] lbuf;
        mlcd_pkg::mlcd_phase_type ph;
        logic [5:0] div_cnt;
        logic half;
        logic [9:0] x;
        logic [8:0] y;
        logic fm;
        logic [8:0] frame;
        logic [6:0] blink_cnt;
        logic blink_hide;
        logic [6:0] alt_cnt;
        logic alt;
        logic [7:0] pwm_cnt;
        logic pwm;
        logic [7:0] data_pin;
        logic fm_pin;
        logic lp_pin;
        logic sck_pin;
    } mlcd_state_type;

    mlcd_state_type s;
    mlcd_state_type next_s;

    // words per line: 16 pixels per word at one bit, 8 at two bits
    function automatic logic [6:0] mlcd_words(input logic [9:0] w, input logic two);
        logic [10:0] sum;
        sum = two ? 11'({1'b0, w} + 11'h007) : 11'({1'b0, w} + 11'h00f);
        mlcd_words = two ? sum[9:3] : sum[10:4];
    endfunction

    // two-bit code of pixel idx; a one-bit pixel becomes 0 or 3
    function automatic logic [1:0] mlcd_pix(input logic [BUF_WORDS-1:0][15:0] b,
                                            input logic [9:0] idx, input logic two);
        logic [15:0] w;
        logic [3:0] sh;
        w = two ? b[idx[9:3]] : b[{1'b0, idx[9:4]}];
        sh = two ? 4'(4'he - {idx[2:0], 1'b0}) : 4'(4'hf - idx[3:0]);
        mlcd_pix = two ? w[sh +: 2] : {2{w[sh]}};
    endfunction

    logic [3:0] bus_w;
    logic [9:0] lane_idx [8];
    logic [1:0] lane_code [8];
    logic [3:0] lane_dens [8];
    logic [3:0] lane_phase [8];
    logic [7:0] lane_on;
    logic [7:0] group;
    logic [6:0] line_words;
    logic tick;
    logic in_x;
    logic in_y;
    logic last_group;
    logic last_line;
    logic fill_start;
    logic alt_event;

    // lane i carries pixel x + bw - 1 - i, so the first pixel sits in the top used lane
    always_comb begin
        bus_w = 4'(4'h1 << panel_interface_config);
        in_y = ({1'b0, s.y} >= {1'b0, cursor_y})
            && ({1'b0, s.y} < 10'({1'b0, cursor_y} + {5'h00, cursor_height}));
        for (int i = 0; i < 8; i++) begin
            lane_idx[i] = 10'(s.x + {6'h00, bus_w} - 10'(i) - 10'h001);
            lane_code[i] = mlcd_pix(s.lbuf, lane_idx[i], two_bit_pixels);
            in_x = ({1'b0, lane_idx[i]} >= {1'b0, cursor_x})
                && ({1'b0, lane_idx[i]} < 11'({1'b0, cursor_x} + {6'h00, cursor_width}));
            // a blink-hidden cursor shows the original pixels
            if (cursor_enable && in_x && in_y && !(cursor_blink_enable && s.blink_hide)) begin
                lane_code[i] = cursor_reverse ? ~lane_code[i] : 2'h3;
            end
            lane_dens[i] = gray_palette_map[{lane_code[i], 2'h0} +: 4];
            lane_phase[i] = 4'(lane_idx[i][3:0] + s.y[3:0]);
        end
    end

    // one modulator per data lane
    for (genvar g = 0; g < 8; g++) begin : gen_lane
        mlcd_frc u_frc (
            .density(lane_dens[g]),
            .frame(s.frame),
            .phase(lane_phase[g]),
            .pixel_on(lane_on[g])
        );
    end

    // pack the group; unused upper lanes stay low
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < bus_w) begin
                group[i] = (two_bit_pixels ? lane_on[i] : lane_code[i][1]) ^ pixel_data_invert;
            end else begin
                group[i] = 1'b0;
            end
        end
    end

    // next state of the whole controller
    always_comb begin
        next_s = s;
        line_words = mlcd_words(screen_width, two_bit_pixels);
        tick = s.div_cnt == display_clocking_control;
        last_group = 11'({1'b0, s.x} + {7'h00, bus_w}) >= {1'b0, screen_width};
        last_line = s.y == 9'(screen_height - 9'h001);
        // no fill is started while the controller is off, so it halts at a line boundary
        fill_start = !s.filled && s.ph != mlcd_pkg::PH_DATA && controller_on
            && s.dma == mlcd_pkg::DMA_IDLE;
        alt_event = 1'b0;

        // contrast modulator, free running
        next_s.pwm_cnt = 8'(s.pwm_cnt + 8'h01);
        next_s.pwm = s.pwm_cnt < contrast_duty;

        // screen dma
        unique case (s.dma)
            mlcd_pkg::DMA_IDLE: begin
                if (fill_start) begin
                    next_s.dma = mlcd_pkg::DMA_REQ;
                    next_s.breq_n = 1'b0;
                    next_s.addr = (s.fetch_y == mlcd_pkg::LINE_RESET) ? screen_start_addr : s.line_addr;
                    next_s.word = 7'h00;
                    next_s.cyc = 4'h0;
                end
            end
            mlcd_pkg::DMA_REQ: begin
                // no memory cycle until the core hands over the bus
                if (!bus_grant_n) begin
                    next_s.dma = mlcd_pkg::DMA_READ;
                    next_s.mrd = 1'b1;
                end
            end
            mlcd_pkg::DMA_READ: begin
                // a setting of zero still gives one clock per word
                if (s.cyc >= 4'(clocks_per_transfer - 4'h1) || clocks_per_transfer == 4'h0) begin
                    next_s.lbuf[s.word] = mem_rdata;
                    next_s.cyc = 4'h0;
                    next_s.addr = 24'(s.addr + mlcd_pkg::WORD_BYTES);
                    next_s.word = 7'(s.word + 7'h01);
                    if (s.word == 7'(line_words - 7'h01)) begin
                        next_s.dma = mlcd_pkg::DMA_IDLE;
                        next_s.breq_n = 1'b1;
                        next_s.mrd = 1'b0;
                        next_s.filled = 1'b1;
                        next_s.line_addr = 24'(s.addr + mlcd_pkg::WORD_BYTES);
                        next_s.fetch_y = (s.fetch_y == 9'(screen_height - 9'h001))
                            ? mlcd_pkg::LINE_RESET : 9'(s.fetch_y + 9'h001);
                    end
                end else begin
                    next_s.cyc = 4'(s.cyc + 4'h1);
                end
            end
            default: begin
                next_s.dma = mlcd_pkg::DMA_IDLE;
                next_s.breq_n = 1'b1;
                next_s.mrd = 1'b0;
            end
        endcase

        // shift clock divider: one tick per half period
        next_s.div_cnt = tick ? 6'h00 : 6'(s.div_cnt + 6'h01);

        // panel sequencer
        unique case (s.ph)
            mlcd_pkg::PH_HOLD: begin
                if (s.filled && tick) begin
                    next_s.ph = mlcd_pkg::PH_DATA;
                    next_s.x = 10'h000;
                    next_s.half = 1'b0;
                end
            end
            mlcd_pkg::PH_DATA: begin
                if (tick && !s.half) begin
                    // data changes as the clock rises; the panel takes it on the fall
                    next_s.data_pin = group;
                    next_s.half = 1'b1;
                end else if (tick) begin
                    next_s.half = 1'b0;
                    next_s.x = 10'(s.x + {6'h00, bus_w});
                    if (last_group) begin
                        next_s.ph = mlcd_pkg::PH_LINE;
                        next_s.filled = 1'b0;
                    end
                end
            end
            mlcd_pkg::PH_LINE: begin
                if (tick) begin
                    next_s.ph = mlcd_pkg::PH_HOLD;
                    alt_event = alternate_on_line;
                    // marker rises after the last line's pulse and falls after the next one
                    next_s.fm = last_line;
                    if (last_line) begin
                        next_s.y = mlcd_pkg::LINE_RESET;
                        next_s.frame = (s.frame == 9'(mlcd_pkg::FRC_PERIOD - 9'h001))
                            ? 9'h000 : 9'(s.frame + 9'h001);
                        if (s.blink_cnt >= blink_control_reg) begin
                            next_s.blink_cnt = 7'h00;
                            next_s.blink_hide = !s.blink_hide;
                        end else begin
                            next_s.blink_cnt = 7'(s.blink_cnt + 7'h01);
                        end
                    end else begin
                        next_s.y = 9'(s.y + 9'h001);
                    end
                end
            end
            default: begin
                next_s.ph = mlcd_pkg::PH_HOLD;
            end
        endcase

        // crystal alternation, counted on marker rises or on line pulses
        if (!alternate_on_line && next_s.fm && !s.fm) begin
            alt_event = 1'b1;
        end
        if (alt_event) begin
            if (s.alt_cnt >= alternate_rate_code) begin
                next_s.alt_cnt = 7'h00;
                next_s.alt = !s.alt;
            end else begin
                next_s.alt_cnt = 7'(s.alt_cnt + 7'h01);
            end
        end

        // pins with their programmed polarity
        next_s.fm_pin = next_s.fm ^ frame_marker_invert;
        next_s.lp_pin = (next_s.ph == mlcd_pkg::PH_LINE) ^ line_pulse_invert;
        next_s.sck_pin = next_s.half ^ shift_clock_invert;
    end

    // single register for the whole state; pins reset to their low level
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s <= '0;
            s.dma <= mlcd_pkg::DMA_IDLE;
            s.ph <= mlcd_pkg::PH_HOLD;
            s.breq_n <= 1'b1;
            s.addr <= mlcd_pkg::ADDR_RESET;
            s.line_addr <= mlcd_pkg::ADDR_RESET;
            s.fetch_y <= mlcd_pkg::LINE_RESET;
            s.y <= mlcd_pkg::LINE_RESET;
            s.alt_cnt <= mlcd_pkg::ALT_COUNT_RESET;
            s.alt <= mlcd_pkg::ALT_OUT_RESET;
            s.pwm_cnt <= mlcd_pkg::PWM_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign bus_request_n = s.breq_n;
    assign mem_addr = s.addr;
    assign mem_read = s.mrd;
    assign panel_pixel_data = s.data_pin;
    assign frame_marker = s.fm_pin;
    assign line_latch_pulse = s.lp_pin;
    assign panel_shift_clock = s.sck_pin;
    assign crystal_alternate_out = s.alt;
    assign contrast_pwm = s.pwm;

endmodule
`default_nettype wire

//--- verification/mlcd_top_assertions.sv
// mlcd_top_assertions: timing checks on the ports of mlcd_top.
// assumes polarity bits only change while nrst is low.
`timescale 1ns/10ps
`default_nettype none
module mlcd_top_assertions (
    input wire logic clk,
    input wire logic nrst,
    input wire logic bus_grant_n,
    input wire logic [3:0] clocks_per_transfer,
    input wire logic [5:0] display_clocking_control,
    input wire logic frame_marker_invert,
    input wire logic line_pulse_invert,
    input wire logic shift_clock_invert,
    input wire logic bus_request_n,
    input wire logic [23:0] mem_addr,
    input wire logic mem_read,
    input wire logic [7:0] panel_pixel_data,
    input wire logic frame_marker,
    input wire logic line_latch_pulse,
    input wire logic panel_shift_clock
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic lp, fm, sck, rd_q, ok;
    logic [1:0] settle;
    logic [23:0] addr_q;
    logic [7:0] word_cnt, lp_cnt, sck_cnt, half, cpt;
    // active levels with polarity removed; a zero transfer count acts as one
    assign lp = line_latch_pulse ^ line_pulse_invert;
    assign fm = frame_marker ^ frame_marker_invert;
    assign sck = panel_shift_clock ^ shift_clock_invert;
    assign half = {2'h0, display_clocking_control} + 8'h01;
    assign cpt = (clocks_per_transfer == 4'h0) ? 8'h01 : {4'h0, clocks_per_transfer};
    assign ok = (settle == 2'h3);
    // run lengths; settle hides edges that still sample reset values
    always_ff @(posedge clk) begin
        settle <= !nrst ? 2'h0 : (ok ? settle : settle + 2'h1);
        rd_q <= mem_read;
        addr_q <= mem_addr;
        word_cnt <= (mem_read && rd_q && mem_addr == addr_q) ? word_cnt + 8'h01 : 8'h01;
        lp_cnt <= lp ? lp_cnt + 8'h01 : 8'h00;
        sck_cnt <= sck ? sck_cnt + 8'h01 : 8'h00;
    end
    sequence next_word;
        mem_read && rd_q && mem_addr != addr_q;
    endsequence
    sequence pulse_end;
        ok && $fell(lp);
    endsequence
    sequence clock_fall;
        ok && $fell(sck);
    endsequence
    chk_read_granted: assert property ($rose(mem_read) |-> $past(bus_grant_n) == 1'b0)
        else $error("read began without grant");
    chk_read_in_req: assert property (mem_read |-> !bus_request_n)
        else $error("read outside request");
    chk_addr_step: assert property (next_word |-> mem_addr == addr_q + 24'h000002)
        else $error("word address step wrong");
    chk_word_len: assert property (next_word |-> word_cnt == cpt)
        else $error("word length wrong");
    chk_req_release: assert property ($rose(bus_request_n) |-> $fell(mem_read))
        else $error("request release out of step");
    chk_pulse_len: assert property (pulse_end |-> lp_cnt == half)
        else $error("line pulse length wrong");
    chk_clock_high: assert property (clock_fall |-> sck_cnt == half)
        else $error("shift clock high time wrong");
    chk_data_steady: assert property (clock_fall |-> $stable(panel_pixel_data))
        else $error("data moved at shift edge");
    chk_marker_moves: assert property (ok && $changed(fm) |-> pulse_end)
        else $error("marker moved off pulse end");
endmodule
bind mlcd_top mlcd_top_assertions mlcd_top_assertions_inst (.clk(clk), .nrst(nrst), .bus_grant_n(bus_grant_n),
    .clocks_per_transfer(clocks_per_transfer), .display_clocking_control(display_clocking_control),
    .frame_marker_invert(frame_marker_invert), .line_pulse_invert(line_pulse_invert),
    .shift_clock_invert(shift_clock_invert), .bus_request_n(bus_request_n), .mem_addr(mem_addr),
    .mem_read(mem_read), .panel_pixel_data(panel_pixel_data), .frame_marker(frame_marker),
    .line_latch_pulse(line_latch_pulse), .panel_shift_clock(panel_shift_clock));
`default_nettype wire

//--- verification/mlcd_panel_model.sv
// mlcd_panel_model: the panel's column and row drivers, receive only.
// assumes polarity and bus width are set while nrst is low.
`timescale 1ns/10ps
`default_nettype none
module mlcd_panel_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] panel_pixel_data,
    input wire logic frame_marker,
    input wire logic line_latch_pulse,
    input wire logic panel_shift_clock,
    input wire logic crystal_alternate_out,
    input wire logic frame_marker_invert,
    input wire logic line_pulse_invert,
    input wire logic shift_clock_invert,
    input wire logic pixel_data_invert,
    input wire logic [1:0] panel_interface_config
);
    logic [639:0] row, last_row;
    logic sck_q, lp_q, fm_q, alt_q, fm_after;
    int n, last_n, lines, frames, last_f, last_l, gap_f, gap_l, live;
    // pins sampled on clk; live skips the edges where reset levels linger
    always @(posedge clk) begin
        logic sck, lp, fm;
        sck = panel_shift_clock ^ shift_clock_invert;
        lp = line_latch_pulse ^ line_pulse_invert;
        fm = frame_marker ^ frame_marker_invert;
        if (!nrst) n = 0;
        // shift on the falling active edge, first pixel in the top used lane
        if (live == 2 && sck_q && !sck) begin
            for (int i = (1 << panel_interface_config) - 1; i >= 0; i--) begin
                if (n < 640) row[n] = panel_pixel_data[i] ^ pixel_data_invert;
                n++;
            end
        end
        // wide latch takes the row as the line pulse ends
        if (live == 2 && lp_q && !lp) begin
            last_row = row;
            last_n = n;
            n = 0;
            lines++;
            fm_after = fm;
        end
        if (live == 2 && fm && !fm_q) frames++;
        // spacing of alternation toggles, in frames and in lines
        if (live == 2 && crystal_alternate_out != alt_q) begin
            gap_f = frames - last_f;
            gap_l = lines - last_l;
            last_f = frames;
            last_l = lines;
        end
        {sck_q, lp_q, fm_q, alt_q} = {sck, lp, fm, crystal_alternate_out};
        live = !nrst ? 0 : (live < 2 ? live + 1 : 2);
    end
endmodule
`default_nettype wire

//--- verification/test_mlcd_top.sv
// test_mlcd_top: random panel set-ups through mlcd_top into the panel model.
// assumes memory answers every address from a fixed pattern.
`timescale 1ns/10ps
`default_nettype none
module test_mlcd_top;
    logic clk = 1'b0;
    logic nrst, controller_on, two_bit_pixels, alternate_on_line, cursor_enable, cursor_reverse;
    logic frame_marker_invert, line_pulse_invert, shift_clock_invert, pixel_data_invert;
    logic bus_grant_n = 1'b1;
    logic [15:0] mem_rdata = 16'h0000;
    logic [15:0] gray_palette_map, pat;
    logic [23:0] screen_start_addr, mem_addr;
    logic [9:0] screen_width, cursor_x;
    logic [8:0] screen_height, cursor_y;
    logic [1:0] panel_interface_config;
    logic [3:0] clocks_per_transfer;
    logic [5:0] display_clocking_control;
    logic [6:0] alternate_rate_code;
    logic [4:0] cursor_width, cursor_height;
    logic [7:0] contrast_duty, panel_pixel_data;
    logic bus_request_n, mem_read, frame_marker, line_latch_pulse, panel_shift_clock, crystal_alternate_out, contrast_pwm;
    logic cursor_blink_enable = 1'b0;
    logic [6:0] blink_control_reg = 7'h00;
    int num_errors = 0, comparisons = 0, cycles = 0, l0;
    mlcd_top mlcd_top_inst (.*);
    mlcd_panel_model mlcd_panel_model_inst (.*);
    always #20 clk = ~clk;
    function automatic logic [15:0] word_of(input logic [23:0] a);
        return a[16:1] ^ pat;
    endfunction
    // on-frames and period per density code
    localparam int on_frames[16] = '{0, 1, 1, 1, 1, 2, 4, 1, 5, 3, 2, 3, 4, 7, 14, 1};
    localparam int period_frames[16] = '{1, 8, 5, 4, 3, 5, 9, 2, 9, 5, 3, 4, 5, 8, 15, 1};
    // pixel seen on the panel in frame f; the phase x + y spreads on-frames
    function automatic logic pix_exp(input int x, input int y, input int f);
        int per;
        logic [15:0] w;
        logic [1:0] code;
        logic [3:0] d;
        per = two_bit_pixels ? 8 : 16;
        w = word_of(screen_start_addr + 24'((y * screen_width / per + x / per) * 2));
        if (!two_bit_pixels) return w[15 - x % 16];
        code = w[15 - 2 * (x % 8) -: 2];
        // a blink-hidden cursor leaves the stored pixels alone
        if (cursor_enable && !(cursor_blink_enable && f / (blink_control_reg + 1) % 2)
            && x >= cursor_x && x < cursor_x + cursor_width && y >= cursor_y && y < cursor_y + cursor_height)
            code = cursor_reverse ? ~code : 2'h3;
        d = gray_palette_map[4 * code +: 4];
        return (f + (x + y) % 16) % period_frames[d] < on_frames[d];
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            num_errors++;
            stop_test();
        end
    end
    // memory answers from the pattern; grant follows the request after a random wait
    always @(negedge clk) begin
        mem_rdata <= word_of(mem_addr);
        if (bus_request_n !== 1'b0) bus_grant_n <= 1'b1;
        else if ($urandom % 3 == 0) bus_grant_n <= 1'b0;
    end
    task automatic setup(input int c);
        nrst = 1'b0;
        controller_on = 1'b1;
        {two_bit_pixels, cursor_enable, panel_interface_config} = {c[1], c[1], 2'(c)};
        {frame_marker_invert, line_pulse_invert, shift_clock_invert, pixel_data_invert} = {4{c[0]}};
        {screen_width, screen_height, screen_start_addr} = {10'(16 * (1 + $urandom % 3)), 9'h003, 24'($urandom) & 24'hfffffe};
        {clocks_per_transfer, display_clocking_control} = {4'($urandom % 4), 6'($urandom % 3)};
        {alternate_on_line, alternate_rate_code} = {1'($urandom), 7'($urandom % 3)};
        {cursor_reverse, cursor_x, cursor_y} = {1'($urandom), 10'($urandom % 48), 9'($urandom % 3)};
        {cursor_width, cursor_height} = {5'(1 + $urandom % 31), 5'(1 + $urandom % 31)};
        {cursor_blink_enable, blink_control_reg} = {c[0], 7'($urandom % 3)};
        for (int k = 0; k < 4; k++)
            gray_palette_map[4 * k +: 4] = 4'($urandom);
        {pat, contrast_duty} = {16'($urandom), 8'h00};
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        l0 = mlcd_panel_model_inst.lines;
    endtask
    task automatic run_lines(input int count);
        int y, t, base, f;
        base = mlcd_panel_model_inst.lines;
        for (int k = 0; k < count; k++) begin
            t = 0;
            while (mlcd_panel_model_inst.lines == base + k && t < 5000) begin
                @(negedge clk);
                t++;
            end
            check("line wait", 32'h0, 32'(t == 5000));
            y = (mlcd_panel_model_inst.lines - l0 - 1) % screen_height;
            f = (mlcd_panel_model_inst.lines - l0 - 1) / screen_height;
            check("row length", 32'(screen_width), mlcd_panel_model_inst.last_n);
            check("frame marker", 32'(y == screen_height - 1), 32'(mlcd_panel_model_inst.fm_after));
            for (int x = 0; x < screen_width; x++)
                check("pixel", 32'(pix_exp(x, y, f)), 32'(mlcd_panel_model_inst.last_row[x]));
        end
    endtask
    task automatic pwm_check(input logic [7:0] d);
        logic [31:0] hi;
        contrast_duty = d;
        repeat (300) @(negedge clk);
        hi = 32'h0;
        repeat (256) begin
            @(negedge clk);
            hi = hi + 32'(contrast_pwm);
        end
        check("contrast high count", 32'(d), hi);
    endtask
    initial begin
        logic [31:0] g, busy;
        int seen;
        void'($urandom(29));
        setup(0);
        // every bus width, both polarities, 1- and 2-bit pixels
        for (int c = 0; c < 4; c++) begin
            if (c > 0) setup(c);
            run_lines(24);
            g = alternate_on_line ? mlcd_panel_model_inst.gap_l : mlcd_panel_model_inst.gap_f;
            check("alternation gap", 32'(alternate_rate_code) + 32'h1, g);
            pwm_check(c == 0 ? 8'h00 : (c == 1 ? 8'hff : 8'($urandom)));
        end
        // switched off: no fills and no lines, then refresh resumes
        controller_on = 1'b0;
        repeat (1500) @(negedge clk);
        seen = mlcd_panel_model_inst.lines;
        busy = 32'h0;
        repeat (2000) begin
            @(negedge clk);
            busy = busy + 32'(bus_request_n === 1'b0);
        end
        check("request while off", 32'h0, busy);
        check("lines while off", seen, mlcd_panel_model_inst.lines);
        controller_on = 1'b1;
        run_lines(3);
        stop_test();
    end
endmodule
`default_nettype wire
